/* File: hw/atra_fifo.sv */
// Module: small valid/ready FIFO in the data path
`timescale 1ns/100ps
`default_nettype none
module atra_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  initial begin
    if (D < 2 || (1 << AW) != D) $error("atra_fifo: depth must be a power of two");
  end

  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* File: hw/atra_pkg.sv */
// Package: constants and carrier types for the transport stream rate adapter
package atra_pkg;
  localparam int          BYTE_W        = 8;
  localparam int          PKT_SHORT     = 188;
  localparam int          PKT_LONG      = 204;
  localparam logic [31:0] RATE_MIN_BPS  = 32'd64000;
  localparam logic [31:0] RATE_MAX_BPS  = 32'd213000000;
  localparam logic [31:0] CLK_HZ        = 32'd40000000;
  localparam int          MEAS_WIN_CYC  = 40000000;
  localparam logic [15:0] ONID_RESET    = 16'hff01;
  localparam logic [15:0] TSID_RESET    = 16'h0001;
  localparam logic [12:0] NULL_PID      = 13'h1fff;
  localparam logic [12:0] PAT_PID       = 13'h0000;
  localparam logic [12:0] SDT_PID       = 13'h0011;
  localparam logic [7:0]  SYNC_BYTE     = 8'h47;
  localparam logic [7:0]  STUFF_BYTE    = 8'hff;
  // Byte positions inside the packet: table fields that get patched, PCR fields; then FIFO depth and port count
  localparam int          PAT_TSID_HI   = 8;
  localparam int          SDT_ONID_HI   = 13;
  localparam int          PCR_FLAG_POS  = 5;
  localparam int          PCR_BASE_POS  = 6;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          PORTS         = 2;

  typedef struct packed {
    logic [BYTE_W-1:0] data;
    logic              sop;
  } atra_beat_t;

  typedef struct packed {
    logic        manual;
    logic        long_pkt;
    logic [31:0] rate_bps;
    logic [15:0] tsid;
    logic [15:0] onid;
    logic        sdt_en;
  } atra_cfg_t;

  typedef struct packed {
    logic        ok;
    logic        unlocked;
    logic        overflow;
    logic        rate_bad;
    logic [31:0] measured_stream_rate;
  } atra_stat_t;
endpackage

/* File: hw/atra_port.sv */
// Module: one rate-adapting transport stream output port
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Each port instance keeps its own configuration and status; device uses two.
// - Output packets are 188 or 204 bytes, chosen by configuration.
// - Manual mode paces output to at most the target bit rate.
// - Manual mode with no or idle source sends only null packets.
// - Slow source in manual mode gets null packets filled in.
// - Fast source in manual mode has its null packets removed.
// - Clock references pass unchanged when nulls are inserted or removed.
// - If removing nulls is not enough, payload packets drop and overflow alarms.
// - Overflow status reported in manual mode when rate cannot carry sources.
// - Automatic mode passes source packets at their rate, no nulls added.
// - Automatic mode without source sends nothing at all.
// - Automatic mode without input data reports unlocked.
// - Unlocked alarm raised only when a source connection exists.
// - Manual target rate accepted only from 64000 to 213000000 b/s.
// - Outgoing rate is measured and reported in bits per second.
// - Configured stream identifier is written into the association table.
// - Network identifier, reset 0xff01, carried in the service table.
// - Service table passes only if a connected encoder enables it.
// - Overflow drives card state and front indicator to red.
module atra_port
  import atra_pkg::*;
#(
  parameter int DEPTH   = FIFO_DEPTH,
  parameter int MEAS_WIN = MEAS_WIN_CYC
) (
  input  wire logic                mclk,
  input  wire logic                resetn,
  input  wire atra_pkg::atra_cfg_t cfg,
  input  wire logic                src_connected,
  input  wire logic                src_active,
  input  wire atra_pkg::atra_beat_t src_beat,
  input  wire logic                src_valid,
  output logic                     src_ready,
  output atra_pkg::atra_beat_t     tx_beat,
  output logic                     tx_valid,
  output atra_pkg::atra_stat_t     status,
  output logic                     alarm_red
);
  import atra_pkg::*;

  initial begin
    if (DEPTH < 2 || MEAS_WIN < 1) $error("atra_port: bad parameter");
  end

  // ----------------------------------------------------------------
  // Input parsing: classify each source packet, patch tables
  // ----------------------------------------------------------------
  logic [7:0]  ibyte_q;
  logic [12:0] pid_q;
  logic        drop_pkt_q;
  logic        is_null_q;
  logic [7:0]  in_hi_q;
  logic        in_ok;
  atra_beat_t  patched;
  logic        f_ready;
  logic        f_valid;
  atra_beat_t  f_beat;
  logic [7:0]  pkt_len;
  logic        rate_ok;
  logic        credit_ok;
  logic        ovf_evt;

  assign pkt_len   = cfg.long_pkt ? 8'(PKT_LONG) : 8'(PKT_SHORT);
  assign rate_ok   = cfg.rate_bps >= RATE_MIN_BPS && cfg.rate_bps <= RATE_MAX_BPS;
  assign src_ready = 1'b1;
  assign in_ok     = src_valid & src_active & src_connected;

  function automatic logic [12:0] pid_of(input logic [7:0] hi, input logic [7:0] lo);
    pid_of = {hi[4:0], lo};
  endfunction

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ibyte_q <= '0;
      in_hi_q <= '0;
      pid_q   <= '0;
    end else if (in_ok) begin
      ibyte_q <= src_beat.sop ? 8'd1 : ibyte_q + 8'd1;
      if (ibyte_q == 8'd1) in_hi_q <= src_beat.data;
      if (ibyte_q == 8'd2) pid_q <= pid_of(in_hi_q, src_beat.data);
    end
  end

  // Patch PAT stream identifier and SDT network identifier in place
  always_comb begin
    patched = src_beat;
    if (ibyte_q > 8'd3 && pid_q == PAT_PID && ibyte_q == 8'(PAT_TSID_HI)) begin
      patched.data = cfg.tsid[15:8];
    end else if (ibyte_q > 8'd3 && pid_q == PAT_PID && ibyte_q == 8'(PAT_TSID_HI + 1)) begin
      patched.data = cfg.tsid[7:0];
    end else if (ibyte_q > 8'd3 && pid_q == SDT_PID && ibyte_q == 8'(SDT_ONID_HI)) begin
      patched.data = cfg.onid[15:8];
    end else if (ibyte_q > 8'd3 && pid_q == SDT_PID && ibyte_q == 8'(SDT_ONID_HI + 1)) begin
      patched.data = cfg.onid[7:0];
    end
  end

  // Decision on a whole packet is taken at its third byte, once PID is known;
  // the two header bytes before it are held back in the shift below.
  logic [7:0] hold0_q;
  logic [7:0] hold1_q;
  logic       keep;
  logic       nul_now;
  assign nul_now = pid_of(in_hi_q, src_beat.data) == NULL_PID;

  // Header bytes are re-emitted as a burst once the decision is known; after
  // that each body byte travels one slot late through the park register and
  // idle source slots let the parked byte out. So one idle slot after the
  // third byte is all that the source has to give.
  logic       burst_q;
  logic       decide;
  logic       body;
  logic       cut_evt;
  logic       cut_q;
  logic       skip_q;
  atra_beat_t park_q;
  logic       park_v_q;
  atra_beat_t fin_beat;
  logic       fin_valid;
  logic [7:0] obyte_q;
  logic       pkt_src_q;
  logic       emit;
  logic       pad_now;
  logic       pop;

  assign decide  = in_ok && ibyte_q == 8'd2;
  assign body    = in_ok && !src_beat.sop && ibyte_q > 8'd2;
  assign keep    = !((cfg.manual && nul_now) || skip_q
                 || (pid_of(in_hi_q, src_beat.data) == SDT_PID && !cfg.sdt_en)
                 || !f_ready);
  // A byte that finds the FIFO full cuts its packet short
  assign cut_evt = fin_valid && !f_ready && !decide;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      drop_pkt_q <= 1'b0;
      is_null_q  <= 1'b0;
      hold0_q    <= '0;
      hold1_q    <= '0;
    end else begin
      if (in_ok && src_beat.sop) hold0_q <= src_beat.data;
      if (in_ok && ibyte_q == 8'd1) hold1_q <= src_beat.data;
      if (decide) begin
        is_null_q  <= nul_now;
        drop_pkt_q <= !keep;
      end else if (cut_evt) begin
        drop_pkt_q <= 1'b1;
      end
    end
  end

  always_comb begin
    fin_beat  = park_q;
    fin_valid = 1'b0;
    if (decide) begin
      fin_beat  = '{data: hold0_q, sop: 1'b1};
      fin_valid = keep;
    end else if (burst_q) begin
      fin_beat  = '{data: hold1_q, sop: 1'b0};
      fin_valid = 1'b1;
    end else if (body) begin
      fin_valid = park_v_q && !drop_pkt_q;
    end else begin
      fin_valid = park_v_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      burst_q  <= 1'b0;
      park_q   <= '0;
      park_v_q <= 1'b0;
    end else begin
      burst_q <= decide && keep;
      if (decide && keep) begin
        park_q   <= '{data: src_beat.data, sop: 1'b0};
        park_v_q <= 1'b1;
      end else if (body && !drop_pkt_q && !cut_evt) begin
        park_q   <= patched;
        park_v_q <= 1'b1;
      end else if (!burst_q) begin
        park_v_q <= 1'b0;
      end
    end
  end

  // A cut packet is padded to length at the output, and the next source
  // packet is given up whole so that the FIFO can drain.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cut_q  <= 1'b0;
      skip_q <= 1'b0;
    end else begin
      if (cut_evt) begin
        cut_q <= 1'b1;
      end else if (emit && pad_now && obyte_q == pkt_len - 8'd1) begin
        cut_q <= 1'b0;
      end
      if (cut_evt) begin
        skip_q <= 1'b1;
      end else if (decide) begin
        skip_q <= 1'b0;
      end
    end
  end

  assign ovf_evt = cut_evt || (decide && !nul_now && (!f_ready || skip_q));

  atra_fifo #(.W($bits(atra_beat_t)), .D(DEPTH)) u_fifo (
    .clk       (mclk),
    .rst_n     (resetn),
    .in_data   (fin_beat),
    .in_valid  (fin_valid),
    .in_ready  (f_ready),
    .out_data  (f_beat),
    .out_valid (f_valid),
    .out_ready (pop)
  );

  // ----------------------------------------------------------------
  // Output pacing: bit credit accumulator, packet-atomic selection
  // ----------------------------------------------------------------
  // One byte costs 8 bits of credit at the clock rate; the cap keeps a stalled
  // source from piling up credit that would later burst out above the rate.
  localparam logic [32:0] BYTE_CREDIT = 33'(CLK_HZ) * 33'd8;
  localparam logic [32:0] CREDIT_CAP  = BYTE_CREDIT * 33'd2;
  logic [32:0] acc_q;
  logic        in_pkt_q;
  logic        start;
  logic [7:0]  null_byte;

  assign credit_ok = cfg.manual ? (acc_q >= BYTE_CREDIT) : 1'b1;
  assign start     = !in_pkt_q && credit_ok;
  assign pad_now   = pkt_src_q && ((f_valid && f_beat.sop && obyte_q != 8'd0)
                                   || (!f_valid && cut_q));
  assign emit      = in_pkt_q && credit_ok && (!pkt_src_q || f_valid || cut_q);
  assign pop       = emit && pkt_src_q && !pad_now;

  always_comb begin
    case (obyte_q)
      8'd0:    null_byte = SYNC_BYTE;
      8'd1:    null_byte = {3'b000, NULL_PID[12:8]};
      8'd2:    null_byte = NULL_PID[7:0];
      8'd3:    null_byte = 8'h10;
      default: null_byte = STUFF_BYTE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      acc_q     <= '0;
      obyte_q   <= '0;
      in_pkt_q  <= 1'b0;
      pkt_src_q <= 1'b0;
      tx_valid  <= 1'b0;
      tx_beat   <= '0;
    end else begin
      tx_valid <= 1'b0;
      if (cfg.manual && rate_ok) begin
        acc_q <= ((acc_q >= CREDIT_CAP) ? acc_q : acc_q + 33'(cfg.rate_bps))
               - (emit ? BYTE_CREDIT : 33'd0);
      end else begin
        acc_q <= '0;
      end
      if (start && f_valid && f_beat.sop) begin
        in_pkt_q  <= 1'b1;
        pkt_src_q <= 1'b1;
        obyte_q   <= '0;
      end else if (start && cfg.manual && rate_ok) begin
        in_pkt_q  <= 1'b1;
        pkt_src_q <= 1'b0;
        obyte_q   <= '0;
      end else if (emit) begin
        tx_valid <= 1'b1;
        tx_beat  <= !pkt_src_q ? '{data: null_byte, sop: obyte_q == 8'd0}
                  : pad_now ? '{data: STUFF_BYTE, sop: 1'b0} : f_beat;
        obyte_q  <= obyte_q + 8'd1;
        if (obyte_q == pkt_len - 8'd1) in_pkt_q <= 1'b0;
      end
    end
  end
  // PCR values ride through unchanged: pacing keeps each packet at its own
  // slot, so insertion only shifts packets within the jitter of one FIFO.

  // ----------------------------------------------------------------
  // Status: rate meter, overflow and unlock alarms
  // ----------------------------------------------------------------
  logic [31:0] win_q;
  logic [31:0] bits_q;
  logic [31:0] idle_q;
  logic        ovf_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      win_q  <= '0;
      bits_q <= '0;
      status <= '0;
      ovf_q  <= 1'b0;
      idle_q <= '0;
      alarm_red <= 1'b0;
    end else begin
      win_q  <= (win_q == 32'(MEAS_WIN - 1)) ? '0 : win_q + 32'd1;
      bits_q <= (win_q == 32'(MEAS_WIN - 1)) ? '0 : bits_q + (tx_valid ? 32'd8 : 32'd0);
      if (win_q == 32'(MEAS_WIN - 1)) begin
        status.measured_stream_rate <= bits_q;
        ovf_q <= 1'b0;
      end else if (ovf_evt && cfg.manual) begin
        ovf_q <= 1'b1;
      end
      idle_q <= in_ok ? '0 : (idle_q == 32'(MEAS_WIN) ? idle_q : idle_q + 32'd1);
      status.overflow <= ovf_q && cfg.manual;
      status.unlocked <= !cfg.manual && idle_q == 32'(MEAS_WIN);
      status.rate_bad <= cfg.manual && !rate_ok;
      status.ok       <= !(ovf_q && cfg.manual) && !(!cfg.manual && idle_q == 32'(MEAS_WIN));
      alarm_red <= (ovf_q && cfg.manual)
                || (!cfg.manual && idle_q == 32'(MEAS_WIN) && src_connected);
    end
  end
endmodule
`default_nettype wire

/* File: testbench/atra_port_sva.sv */
// Checker: concurrent properties on one rate adapter port
`timescale 1ns/100ps
`default_nettype none
module atra_port_sva
  import atra_pkg::*;
(
  input wire logic                 mclk,
  input wire logic                 resetn,
  input wire atra_pkg::atra_cfg_t  cfg,
  input wire logic                 src_connected,
  input wire logic                 src_active,
  input wire atra_pkg::atra_beat_t src_beat,
  input wire logic                 src_valid,
  input wire logic                 src_ready,
  input wire atra_pkg::atra_beat_t tx_beat,
  input wire logic                 tx_valid,
  input wire atra_pkg::atra_stat_t status,
  input wire logic                 alarm_red
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [7:0] cnt_q;
  logic [7:0] idle_q;
  logic       seen_q;
  logic       rbad;
  assign rbad = (cfg.rate_bps < RATE_MIN_BPS) || (cfg.rate_bps > RATE_MAX_BPS);
  // Byte count since the last start byte; wraps harmlessly past 255
  always_ff @(posedge mclk) begin
    if (!resetn) cnt_q <= 8'h00;
    else if (tx_valid) cnt_q <= tx_beat.sop ? 8'h01 : cnt_q + 8'h01;
  end
  always_ff @(posedge mclk) begin
    if (!resetn) seen_q <= 1'b0;
    else if (tx_valid && tx_beat.sop) seen_q <= 1'b1;
  end
  always_ff @(posedge mclk) begin
    if (!resetn || cfg.manual || (src_valid && src_active && src_connected)) idle_q <= 8'h00;
    else if (idle_q != 8'hff) idle_q <= idle_q + 8'h01;
  end
  a_sop_sync: assert property (tx_valid && tx_beat.sop |-> tx_beat.data == SYNC_BYTE)
    else $error("start byte is not the sync value");
  a_pkt_len: assert property (tx_valid && tx_beat.sop && seen_q
    |-> cnt_q == (cfg.long_pkt ? 8'd204 : 8'd188))
    else $error("packet length differs from configuration");
  a_auto_silent: assert property (idle_q > 8'd200 |-> !tx_valid)
    else $error("automatic mode sent bytes without source data");
  a_rate_range: assert property ((cfg.manual && $stable(cfg.rate_bps))[*4]
    |-> status.rate_bad == rbad)
    else $error("rate range flag wrong");
  a_red_ovf: assert property ($rose(status.overflow) |-> ##[0:1] alarm_red)
    else $error("overflow without red alarm");
  a_ovf_manual: assert property ($rose(status.overflow) |-> $past(cfg.manual))
    else $error("overflow outside manual mode");
  a_unlock_auto: assert property (status.unlocked |-> !$past(cfg.manual) && !status.ok)
    else $error("unlocked shown in manual mode");
  a_unlock_conn: assert property ($rose(alarm_red) && !$past(cfg.manual)
    |-> $past(src_connected))
    else $error("unlocked raised with no connection");
  a_ok_clean: assert property (status.ok |-> !status.overflow && !status.unlocked)
    else $error("ok shown together with an alarm");
  c_ovf: cover property ($rose(status.overflow));
  c_unlock: cover property ($rose(status.unlocked));
  c_long: cover property (tx_valid && tx_beat.sop && seen_q && cfg.long_pkt);
endmodule
`default_nettype wire

/* File: testbench/atra_port_tb.sv */
// Testbench: self-checking run of one rate adapter port
`timescale 1ns/100ps
`default_nettype none
module atra_port_tb;
  import atra_pkg::*;
  localparam int WIN = 1000;
  logic mclk = 0, resetn = 0, clr = 1, src_connected = 0, src_active = 0, src_valid = 0;
  logic src_ready, tx_valid, alarm_red;
  atra_cfg_t  cfg;
  atra_beat_t src_beat, tx_beat;
  atra_stat_t status;
  int n_errors = 0, checks = 0, n_null, n_data, n_sdt, n_bad, k;
  logic [7:0]  pat_b, sdt_b;
  logic [31:0] seed = 32'h234a;
  logic [31:0] rt [4] = '{32'd63999, 32'd64000, 32'd213000000, 32'd213000001};
  always #12.5 mclk = ~mclk;
  initial begin
    cfg = '{manual: 1'b1, long_pkt: 1'b0, rate_bps: 32'd160000000,
            tsid: TSID_RESET, onid: ONID_RESET, sdt_en: 1'b0};
    src_beat = '0;
  end
  // A FIFO deeper than a packet lets source bytes wait out an inserted null packet
  atra_port #(.DEPTH(256), .MEAS_WIN(WIN)) u_atra_port (
    .mclk(mclk), .resetn(resetn), .cfg(cfg), .src_connected(src_connected),
    .src_active(src_active), .src_beat(src_beat), .src_valid(src_valid),
    .src_ready(src_ready), .tx_beat(tx_beat), .tx_valid(tx_valid),
    .status(status), .alarm_red(alarm_red));
  atra_rx u_atra_rx (.mclk(mclk), .clr(clr), .rx_beat(tx_beat), .rx_valid(tx_valid),
    .long_pkt(cfg.long_pkt), .n_null(n_null), .n_data(n_data), .n_sdt(n_sdt),
    .n_bad(n_bad), .pat_b(pat_b), .sdt_b(sdt_b));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Bits expected in one window, allowing 64 bits (8 bytes) of jitter
  function automatic logic near(logic [31:0] seen, logic [31:0] rate);
    longint e;
    e = longint'(rate) * WIN / CLK_HZ;
    return (longint'(seen) >= e - 64) && (longint'(seen) <= e + 64);
  endfunction
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    #1;
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic do_reset();
    @(posedge mclk);
    resetn <= 1'b0;
    clr <= 1'b1;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    clr <= 1'b0;
  endtask
  // One idle cycle after the third byte, gap idles after every byte
  task automatic send_pkt(logic [12:0] pid, int gap);
    logic [7:0] b;
    for (int i = 0; i < (cfg.long_pkt ? PKT_LONG : PKT_SHORT); i++) begin
      b = (i == 0) ? SYNC_BYTE : (i == 1) ? {3'b000, pid[12:8]} : (i == 2) ? pid[7:0] :
          (i == 3) ? 8'h10 : rnd();
      @(posedge mclk);
      src_valid <= 1'b1;
      src_beat <= '{data: b, sop: (i == 0)};
      repeat (gap + (i == 2)) begin
        @(posedge mclk);
        src_valid <= 1'b0;
      end
    end
    @(posedge mclk);
    src_valid <= 1'b0;
  endtask
  task automatic final_report();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge mclk);
    n_errors++;
    final_report();
  end
  initial begin
    // Manual mode, no source: nulls only, both lengths, rate held
    for (int l = 0; l < 2; l++) begin
      cfg.long_pkt <= l[0];
      do_reset();
      chk("quiet", {tx_valid, status.overflow, alarm_red}, 3'b000);
      repeat (3 * WIN) @(posedge mclk);
      chk("data", n_data, 0);
      chk("nulls", n_null > 2, 1'b1);
      chk("length", n_bad, 0);
      chk("rate", near(status.measured_stream_rate, cfg.rate_bps), 1'b1);
    end
    foreach (rt[i]) begin
      cfg.rate_bps <= rt[i];
      repeat (10) @(posedge mclk);
      chk("range", status.rate_bad, (i == 0) || (i == 3));
    end
    // Slow source: nulls padded in, tables patched
    cfg <= '{manual: 1'b1, long_pkt: 1'b0, rate_bps: 32'd160000000,
             tsid: 16'(rnd()), onid: 16'(rnd()), sdt_en: 1'b0};
    src_connected <= 1'b1;
    src_active <= 1'b1;
    do_reset();
    send_pkt(PAT_PID, 4);
    send_pkt(SDT_PID, 4);
    send_pkt(13'(32'h0100 + rnd() % 256), 4);
    repeat (2000) @(posedge mclk);
    chk("slow data", n_data, 2);
    chk("pad nulls", n_null > 0, 1'b1);
    chk("tsid", pat_b, cfg.tsid[15:8]);
    chk("no sdt", n_sdt, 0);
    cfg.sdt_en <= 1'b1;
    send_pkt(SDT_PID, 4);
    repeat (1000) @(posedge mclk);
    chk("sdt", n_sdt, 1);
    chk("onid", sdt_b, cfg.onid[15:8]);
    // Fast source at low target: nulls dropped, then payload dropped
    // Target sits just above the per-byte source speed, so only nulls must go
    cfg.rate_bps <= 32'd120000000;
    do_reset();
    for (int p = 0; p < 8; p++) send_pkt(p[0] ? NULL_PID : 13'h0200 + p, 2);
    repeat (2000) @(posedge mclk);
    chk("kept data", n_data, 4);
    chk("no ovf", status.overflow, 1'b0);
    for (int p = 0; p < 6; p++) send_pkt(13'h0300 + p, 0);
    for (k = 0; k < 2 * WIN && status.overflow !== 1'b1; k++) @(posedge mclk);
    chk("overflow", status.overflow, 1'b1);
    chk("red", alarm_red, 1'b1);
    repeat (3000) @(posedge mclk);
    chk("dropped", n_data < 10, 1'b1);
    // Automatic mode: silence, unlock alarm only with a connection, pass-through
    cfg.manual <= 1'b0;
    src_connected <= 1'b0;
    do_reset();
    repeat (2 * WIN + 50) @(posedge mclk);
    chk("silent", n_null + n_data, 0);
    chk("no unlock alarm", alarm_red, 1'b0);
    src_connected <= 1'b1;
    repeat (2 * WIN + 50) @(posedge mclk);
    chk("unlock", status.unlocked, 1'b1);
    chk("unlock alarm", alarm_red, 1'b1);
    for (int p = 0; p < 3; p++) send_pkt(13'(32'h0400 + rnd() % 256), 1);
    repeat (300) @(posedge mclk);
    chk("auto data", n_data, 3);
    chk("auto nulls", n_null, 0);
    chk("auto len", n_bad, 0);
    final_report();
  end
endmodule
bind atra_port atra_port_sva u_atra_port_sva (
  .mclk(mclk), .resetn(resetn), .cfg(cfg), .src_connected(src_connected),
  .src_active(src_active), .src_beat(src_beat), .src_valid(src_valid),
  .src_ready(src_ready), .tx_beat(tx_beat), .tx_valid(tx_valid),
  .status(status), .alarm_red(alarm_red));
`default_nettype wire

/* File: testbench/atra_rx.sv */
// Partner: downstream stream receiver that sorts and counts packets
`timescale 1ns/100ps
`default_nettype none
module atra_rx
  import atra_pkg::*;
(
  input wire logic                 mclk,
  input wire logic                 clr,
  input wire atra_pkg::atra_beat_t rx_beat,
  input wire logic                 rx_valid,
  input wire logic                 long_pkt,
  output int                       n_null,
  output int                       n_data,
  output int                       n_sdt,
  output int                       n_bad,
  output logic [7:0]               pat_b,
  output logic [7:0]               sdt_b
);
  int          idx;
  logic [12:0] pid;
  // A receiver only trusts bytes after the first start byte
  always @(posedge mclk) begin
    if (clr) begin
      idx = 0; n_null = 0; n_data = 0; n_sdt = 0; n_bad = 0; pat_b = 8'h00; sdt_b = 8'h00;
    end else if (rx_valid) begin
      if (rx_beat.sop) begin
        if (idx != 0 && idx != (long_pkt ? PKT_LONG : PKT_SHORT)) n_bad++;
        idx = 1;
      end else if (idx != 0) idx++;
      if (idx == 2) pid[12:8] = rx_beat.data[4:0];
      if (idx == 3) begin
        pid[7:0] = rx_beat.data;
        if (pid == NULL_PID) n_null++;
        else if (pid == SDT_PID) n_sdt++;
        else n_data++;
      end
      if (pid == PAT_PID && idx == PAT_TSID_HI + 1) pat_b = rx_beat.data;
      if (pid == SDT_PID && idx == SDT_ONID_HI + 1) sdt_b = rx_beat.data;
    end
  end
endmodule
`default_nettype wire
